// File: rtl/osr_record.sv
// op sample retire record: op tagging, capture and retire-time publication
// Operation
// - retired-branch flag set for architectural branches
// - mispredict and taken flags encode independently
// - return flag only for returns, with mispredict
// - resync recorded as not predicted, taken
// - cycle counts valid for every sampled op
// - publish only retired samples, drop flushed
// - mispredicted branch retires, then kills, redirects
// - mispredict and taken flags also cover microcode control flow
// - separate linear and physical address valid bits
// - physical valid allowed without linear valid
// - separate load and store initiated flags
// - load miss latency counted, zero for stores
// - separate first and second level tlb misses
// - flag 2m/1g first level, 2m second level
// - flag cache miss and 128-bit boundary crossing
// - separate bank conflict with load, store
// - flag store forwarding and forwarding cancelled
// - uncacheable, write-combining, locked each own bit
// - flag hit on allocated miss address buffer
// - flag initial data cache miss
// - 20-bit count per cycle, tag at maximum
// - after flush reload count with random 7 bits
// - interrupt raised when tagged op retires
// - tag at decode exit, starts tag count
`timescale 1ns/10ps
`default_nettype none
module osr_record
  import osr_pkg::*;
#(
  parameter int unsigned LAT_W = OSR_LAT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sample_en,
  input wire logic [OSR_MAX_HI_W-1:0] max_count_hi,
  input wire logic decode_exit,
  input wire logic tagged_complete,
  input wire logic tagged_flush,
  input wire logic tagged_retire,
  input wire osr_ret_info_t retire_info,
  input wire logic mem_info_valid,
  input wire osr_mem_flags_t mem_info,
  input wire logic miss_detect,
  input wire logic miss_data_return,
  input wire logic msr_rd_en,
  input wire logic [1:0] msr_rd_sel,
  input wire logic irq_ack,
  output logic tag_op,
  output logic kill_younger,
  output logic front_end_redirect,
  output logic sample_irq,
  output logic msr_rd_valid,
  output logic [OSR_MSR_W-1:0] msr_rd_data
);

  function automatic logic [LAT_W-1:0] sat_inc(input logic [LAT_W-1:0] v);
    sat_inc = (&v) ? v : v + LAT_W'(1);
  endfunction : sat_inc

  osr_state_t state_q, state_d;
  logic [OSR_CNT_W-1:0] cur_cnt_q, cur_cnt_d;
  logic [OSR_RAND_W-1:0] lfsr_q;
  logic [LAT_W-1:0] tag_ret_q, comp_ret_q, miss_lat_q;
  logic completed_q, miss_run_q, miss_done_q;
  osr_mem_flags_t mem_q;
  logic [OSR_MSR_W-1:0] pub_branch_q, pub_memory_q;
  logic tag_op_q, kill_q, redirect_q, irq_q;
  logic rd_valid_q;
  logic [OSR_MSR_W-1:0] rd_data_q;

  wire [OSR_CNT_W-1:0] max_count = {max_count_hi, {OSR_MAX_LO_W{1'b0}}};
  wire count_hit = (cur_cnt_q >= max_count);
  wire armed = (state_q == OSR_ST_ARMED);
  wire inflight = (state_q == OSR_ST_INFLIGHT);
  wire take_tag = armed && decode_exit;
  wire do_retire = inflight && tagged_retire;
  wire do_flush = inflight && tagged_flush && !tagged_retire;
  wire lfsr_fb = ^(lfsr_q & OSR_LFSR_TAPS);

  // branch status composed at retire time
  wire any_branch = retire_info.arch_branch || retire_info.ucode_branch;
  osr_brn_flags_t brn;
  assign brn.retired_branch_flag = retire_info.arch_branch;
  // a resync op is never predicted and always taken
  assign brn.branch_mispredict_flag = retire_info.is_resync ? 1'b0 :
                                      any_branch && retire_info.mispredict;
  assign brn.branch_taken_flag = retire_info.is_resync ? 1'b1 :
                                 any_branch && retire_info.taken;
  assign brn.return_op_flag = retire_info.is_return;
  // meaningless without the return flag, so forced clear
  assign brn.return_mispredict_flag = retire_info.is_return &&
                                      retire_info.return_mispredict;
  assign brn.resync_op_flag = retire_info.is_resync;

  // final counts include the retire cycle itself
  wire [LAT_W-1:0] tag_ret_fin = sat_inc(tag_ret_q);
  wire [LAT_W-1:0] comp_ret_fin = completed_q ? sat_inc(comp_ret_q) : '0;
  // stores may retire before their miss resolves, so latency is loads only
  wire [LAT_W-1:0] lat_fin = (mem_q.load_initiated_flag && miss_done_q) ?
                             miss_lat_q : '0;

  wire [OSR_MSR_W-1:0] branch_word =
    (OSR_MSR_W'(comp_ret_fin) << OSR_B_COMP_LSB) |
    (OSR_MSR_W'(tag_ret_fin) << OSR_B_TAG_LSB) |
    (OSR_MSR_W'(brn) << OSR_B_FLAGS_LSB);
  wire [OSR_MSR_W-1:0] memory_word =
    (OSR_MSR_W'(mem_q) << OSR_M_FLAGS_LSB) |
    (OSR_MSR_W'(lat_fin) << OSR_M_LAT_LSB);

  wire mispredict_retire = do_retire && brn.branch_mispredict_flag;
  wire [OSR_MSR_W-1:0] rd_mux =
    (msr_rd_sel == OSR_SEL_BRANCH) ? pub_branch_q :
    (msr_rd_sel == OSR_SEL_MEMORY) ? pub_memory_q : OSR_RESET_VAL;

  always_comb begin
    state_d = state_q;
    cur_cnt_d = cur_cnt_q;
    case (state_q)
      OSR_ST_COUNT: begin
        if (sample_en) begin
          cur_cnt_d = cur_cnt_q + OSR_CNT_W'(1);
          if (count_hit) begin
            state_d = OSR_ST_ARMED;
          end
        end
      end
      OSR_ST_ARMED: begin
        if (take_tag) begin
          state_d = OSR_ST_INFLIGHT;
          cur_cnt_d = '0;
        end
      end
      OSR_ST_INFLIGHT: begin
        if (do_retire) begin
          state_d = OSR_ST_COUNT;
        end else if (do_flush) begin
          state_d = OSR_ST_COUNT;
          cur_cnt_d = OSR_CNT_W'(lfsr_q);
        end
      end
      default: begin
        state_d = OSR_ST_COUNT;
        cur_cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= OSR_ST_COUNT;
      cur_cnt_q <= '0;
      lfsr_q <= OSR_LFSR_SEED;
    end else begin
      state_q <= state_d;
      cur_cnt_q <= cur_cnt_d;
      lfsr_q <= {lfsr_q[OSR_RAND_W-2:0], lfsr_fb};
    end
  end

  // working cycle counters for the op in flight
  always_ff @(posedge mclk) begin
    if (rst || take_tag) begin
      tag_ret_q <= '0;
      comp_ret_q <= '0;
      completed_q <= 1'b0;
    end else if (inflight) begin
      tag_ret_q <= sat_inc(tag_ret_q);
      if (completed_q) begin
        comp_ret_q <= sat_inc(comp_ret_q);
      end else if (tagged_complete) begin
        completed_q <= 1'b1;
      end
    end
  end

  // miss latency: from miss detection to data delivery
  always_ff @(posedge mclk) begin
    if (rst || take_tag) begin
      miss_lat_q <= '0;
      miss_run_q <= 1'b0;
      miss_done_q <= 1'b0;
    end else if (inflight) begin
      if (miss_run_q) begin
        miss_lat_q <= sat_inc(miss_lat_q);
        if (miss_data_return) begin
          miss_run_q <= 1'b0;
          miss_done_q <= 1'b1;
        end
      end else if (miss_detect && !miss_done_q) begin
        miss_run_q <= 1'b1;
      end
    end
  end

  // memory flags accumulate; several reports may arrive per op
  always_ff @(posedge mclk) begin
    if (rst || take_tag) begin
      mem_q <= '0;
    end else if (inflight && mem_info_valid) begin
      // each flag is its own bit, so physical may stand alone
      mem_q <= mem_q | mem_info;
    end
  end

  // published record only changes on retire; flushed samples never reach it
  always_ff @(posedge mclk) begin
    if (rst) begin
      pub_branch_q <= OSR_RESET_VAL;
      pub_memory_q <= OSR_RESET_VAL;
    end else if (do_retire) begin
      pub_branch_q <= branch_word;
      pub_memory_q <= memory_word;
    end
  end

  // control pulses and interrupt level
  always_ff @(posedge mclk) begin
    if (rst) begin
      tag_op_q <= 1'b0;
      kill_q <= 1'b0;
      redirect_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      tag_op_q <= take_tag;
      // the retire has been taken this cycle, kill follows one cycle later
      kill_q <= mispredict_retire;
      redirect_q <= mispredict_retire;
      // new retire wins over an acknowledge in the same cycle
      if (do_retire) begin
        irq_q <= 1'b1;
      end else if (irq_ack) begin
        irq_q <= 1'b0;
      end
    end
  end

  // register read port, answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= OSR_RESET_VAL;
    end else begin
      rd_valid_q <= msr_rd_en;
      if (msr_rd_en) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign tag_op = tag_op_q;
  assign kill_younger = kill_q;
  assign front_end_redirect = redirect_q;
  assign sample_irq = irq_q;
  assign msr_rd_valid = rd_valid_q;
  assign msr_rd_data = rd_data_q;

endmodule : osr_record
`default_nettype wire

// File: include/osr_pkg.sv
// shared types and constants for the op sample retire record
package osr_pkg;
  localparam int unsigned OSR_CNT_W = 20;
  localparam int unsigned OSR_MAX_HI_W = 16;
  localparam int unsigned OSR_MAX_LO_W = 4;
  localparam int unsigned OSR_RAND_W = 7;
  localparam int unsigned OSR_LAT_W = 16;
  localparam int unsigned OSR_MSR_W = 64;
  localparam logic [6:0] OSR_LFSR_SEED = 7'h5a;
  localparam logic [6:0] OSR_LFSR_TAPS = 7'h60;

  // read selects for the two record registers
  localparam logic [1:0] OSR_SEL_BRANCH = 2'h0;
  localparam logic [1:0] OSR_SEL_MEMORY = 2'h1;

  // op_branch_status_and_latency layout
  localparam int unsigned OSR_B_COMP_LSB = 0;
  localparam int unsigned OSR_B_TAG_LSB = 16;
  localparam int unsigned OSR_B_FLAGS_LSB = 32;
  // op_memory_access_info layout
  localparam int unsigned OSR_M_FLAGS_LSB = 0;
  localparam int unsigned OSR_M_LAT_LSB = 32;
  localparam logic [OSR_MSR_W-1:0] OSR_RESET_VAL = 64'h0;

  // branch status flags, msb first in register order from bit 37 down to 32
  typedef struct packed {
    logic resync_op_flag;
    logic return_mispredict_flag;
    logic return_op_flag;
    logic branch_taken_flag;
    logic branch_mispredict_flag;
    logic retired_branch_flag;
  } osr_brn_flags_t;

  // what retire logic reports about the tagged op
  typedef struct packed {
    logic arch_branch;
    logic ucode_branch;
    logic mispredict;
    logic taken;
    logic is_return;
    logic return_mispredict;
    logic is_resync;
  } osr_ret_info_t;

  // memory flags, msb first from bit 18 down to bit 0
  typedef struct packed {
    logic physical_address_valid;
    logic linear_address_valid;
    logic miss_buffer_hit_flag;
    logic locked_access_flag;
    logic write_combining_access_flag;
    logic uncacheable_access_flag;
    logic store_forward_cancelled;
    logic store_forwarded_flag;
    logic bank_conflict_with_store;
    logic bank_conflict_with_load;
    logic misaligned_access_flag;
    logic data_cache_miss_flag;
    logic second_level_data_translation_buffer_2m_hit;
    logic first_level_data_translation_buffer_1g_hit;
    logic first_level_data_translation_buffer_2m_hit;
    logic second_level_data_translation_buffer_miss;
    logic first_level_data_translation_buffer_miss;
    logic store_initiated_flag;
    logic load_initiated_flag;
  } osr_mem_flags_t;

  typedef enum logic [1:0] {
    OSR_ST_COUNT,
    OSR_ST_ARMED,
    OSR_ST_INFLIGHT
  } osr_state_t;
endpackage : osr_pkg

// File: tb/osr_record_asserts.sv
// port-level assertion checker for the op sample retire record
`timescale 1ns/10ps
`default_nettype none
module osr_record_asserts import osr_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic decode_exit,
  input wire logic tagged_flush,
  input wire logic tagged_retire,
  input wire osr_ret_info_t retire_info,
  input wire logic msr_rd_en,
  input wire logic [1:0] msr_rd_sel,
  input wire logic irq_ack,
  input wire logic tag_op,
  input wire logic kill_younger,
  input wire logic front_end_redirect,
  input wire logic sample_irq,
  input wire logic msr_rd_valid,
  input wire logic [OSR_MSR_W-1:0] msr_rd_data
);
  // resync ops never count as mispredicted, so they never kill
  wire logic misp_ret = tagged_retire && retire_info.mispredict && !retire_info.is_resync
    && (retire_info.arch_branch || retire_info.ucode_branch);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_tag_at_decode: assert property (tag_op |-> $past(decode_exit))
    else $error("tag without decode exit");
  a_tag_one_pulse: assert property (tag_op |=> !tag_op)
    else $error("tag pulse too long");
  a_irq_on_retire: assert property ($rose(sample_irq) |-> $past(tagged_retire))
    else $error("irq without retire");
  a_flush_no_irq: assert property (tagged_flush && !tagged_retire && !sample_irq |=> !sample_irq)
    else $error("irq after flush");
  a_ack_clears_irq: assert property (irq_ack && !tagged_retire |=> !sample_irq)
    else $error("irq not cleared");
  a_kill_pair: assert property (kill_younger == front_end_redirect)
    else $error("kill and redirect differ");
  a_kill_cause: assert property (kill_younger |-> $past(misp_ret))
    else $error("kill without mispredict");
  a_kill_on_misp: assert property (misp_ret |=> kill_younger)
    else $error("mispredict without kill");
  a_rd_answer: assert property (msr_rd_en |=> msr_rd_valid)
    else $error("read not answered");
  a_rd_unmapped: assert property (msr_rd_en && msr_rd_sel[1] |=> msr_rd_data == 64'h0)
    else $error("unmapped read not zero");
endmodule : osr_record_asserts
bind osr_record osr_record_asserts u_chk (.mclk, .rst, .decode_exit, .tagged_flush,
  .tagged_retire, .retire_info, .msr_rd_en, .msr_rd_sel, .irq_ack, .tag_op, .kill_younger,
  .front_end_redirect, .sample_irq, .msr_rd_valid, .msr_rd_data);
`default_nettype wire

// File: tb/osr_pipe_model.sv
// pipeline model: decode stream, completion, memory reports and retire or flush
`timescale 1ns/10ps
`default_nettype none
module osr_pipe_model import osr_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tag_op,
  input wire logic do_flush,
  input wire osr_mem_flags_t mem_pat,
  output logic decode_exit,
  output logic tagged_complete,
  output logic tagged_flush,
  output logic tagged_retire,
  output logic mem_info_valid,
  output var osr_mem_flags_t mem_info,
  output logic miss_detect,
  output logic miss_data_return
);
  int n = -1;
  initial {decode_exit, tagged_complete, tagged_flush, tagged_retire} = '0;
  initial {mem_info_valid, miss_detect, miss_data_return} = '0;
  // fixed op life: complete at step 2, miss from 1 to 3, retire or flush at 5
  always @(negedge mclk) begin
    if (tag_op === 1'b1) n = 0;
    else if (n >= 0) n = n + 1;
    if (rst || n > 5) n = -1;
    decode_exit <= !rst;
    mem_info_valid <= (n == 1);
    miss_detect <= (n == 1);
    tagged_complete <= (n == 2);
    miss_data_return <= (n == 3);
    tagged_retire <= (n == 5) && !do_flush;
    tagged_flush <= (n == 5) && do_flush;
  end
  // outside its report cycle the flag bus carries junk, not the last value
  assign mem_info = mem_info_valid ? mem_pat : ~mem_pat;
endmodule : osr_pipe_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the op sample retire record
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import osr_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, sample_en = 1'b0, msr_rd_en = 1'b0, irq_ack = 1'b0;
  logic do_flush = 1'b0;
  logic [15:0] max_hi = 16'h0000;
  int tag_wait = 0;
  logic [1:0] msr_rd_sel = 2'h0;
  osr_ret_info_t retire_info = '0;
  osr_mem_flags_t mem_pat = '0, mem_info;
  logic decode_exit, tagged_complete, tagged_flush, tagged_retire, mem_info_valid;
  logic miss_detect, miss_data_return, tag_op, kill_younger, front_end_redirect;
  logic sample_irq, msr_rd_valid;
  logic [63:0] msr_rd_data, last_b = 64'h0, last_m = 64'h0;
  int fails = 0, checks_done = 0, kills = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (kill_younger === 1'b1) kills <= kills + 1;
  osr_pipe_model u_pipe (.mclk, .rst, .tag_op, .do_flush, .mem_pat, .decode_exit,
    .tagged_complete, .tagged_flush, .tagged_retire, .mem_info_valid, .mem_info,
    .miss_detect, .miss_data_return);
  osr_record u_dut (.mclk, .rst, .sample_en, .max_count_hi(max_hi), .decode_exit,
    .tagged_complete, .tagged_flush, .tagged_retire, .retire_info, .mem_info_valid,
    .mem_info, .miss_detect, .miss_data_return, .msr_rd_en, .msr_rd_sel, .irq_ack,
    .tag_op, .kill_younger, .front_end_redirect, .sample_irq, .msr_rd_valid, .msr_rd_data);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic limit(input int k, input int lim);
    if (k >= lim) begin
      fails++;
      close_out();
    end
  endtask : limit
  task automatic rd(input logic [1:0] sel, input logic [63:0] exp);
    msr_rd_en = 1'b1;
    msr_rd_sel = sel;
    @(negedge mclk);
    msr_rd_en = 1'b0;
    check({63'h0, msr_rd_valid}, 64'h1);
    check(msr_rd_data, exp);
    @(negedge mclk);
  endtask : rd
  // counts are fixed by the model: tag to retire 6, completion to retire 3, miss 2
  task automatic sample(input string nm, input osr_ret_info_t ri, input osr_mem_flags_t mp,
      input logic fl, input logic [5:0] fb, input logic [15:0] lat, input int ek);
    int k;
    int k0;
    k0 = kills;
    retire_info = ri;
    mem_pat = mp;
    do_flush = fl;
    sample_en = 1'b1;
    // long enough for a full 7-bit reload distance to a programmed maximum of 128
    for (k = 0; k < 200 && tag_op !== 1'b1; k++) @(negedge mclk);
    sample_en = 1'b0;
    tag_wait = k;
    limit(k, 200);
    for (k = 0; k < 30 && sample_irq !== 1'b1; k++) @(negedge mclk);
    if (!fl) begin
      limit(k, 30);
      last_b = {26'h0, fb, 16'h0006, 16'h0003};
      last_m = {16'h0, lat, 13'h0, mp};
    end
    check({63'h0, sample_irq}, {63'h0, !fl});
    rd(OSR_SEL_BRANCH, last_b);
    rd(OSR_SEL_MEMORY, last_m);
    check(64'(kills - k0), 64'(ek));
    irq_ack = 1'b1;
    @(negedge mclk);
    irq_ack = 1'b0;
    @(negedge mclk);
    check({63'h0, sample_irq}, 64'h0);
    $display("test %s done", nm);
  endtask : sample
  task automatic s_branch();
    sample("branch", 7'b1011000, 19'h00885, 1'b0, 6'b000111, 16'h0002, 1);
  endtask : s_branch
  task automatic s_ucode();
    sample("ucode", 7'b0110000, 19'h3fffc, 1'b0, 6'b000010, 16'h0000, 1);
  endtask : s_ucode
  task automatic s_resync();
    sample("resync", 7'b0110011, 19'h00000, 1'b0, 6'b100100, 16'h0000, 0);
  endtask : s_resync
  task automatic s_return();
    sample("return", 7'b1001110, 19'h40002, 1'b0, 6'b011101, 16'h0000, 0);
  endtask : s_return
  task automatic s_flush();
    sample("flush", 7'b1011000, 19'h00885, 1'b1, 6'b000111, 16'h0002, 0);
  endtask : s_flush
  // after the flush the count restarts from a nonzero 7-bit value, so the wait
  // to a maximum of 128 lies between 3 and 129 edges; 130 means no reload
  task automatic s_plain();
    max_hi = 16'h0008;
    sample("plain", 7'b0011000, 19'h00003, 1'b0, 6'b000000, 16'h0002, 0);
    check(64'(tag_wait >= 3 && tag_wait <= 129), 64'h1);
    max_hi = 16'h0000;
  endtask : s_plain
  // count from zero to 16, one edge to arm, one edge to tag
  task automatic s_period();
    max_hi = 16'h0001;
    sample("period", 7'h00, 19'h00000, 1'b0, 6'h00, 16'h0000, 0);
    check(64'(tag_wait), 64'h12);
    max_hi = 16'h0000;
  endtask : s_period
  task automatic s_unmapped();
    rd(2'h2, 64'h0);
    rd(2'h3, 64'h0);
    $display("test unmapped done");
  endtask : s_unmapped
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    s_branch();
    s_ucode();
    s_resync();
    s_return();
    s_flush();
    s_plain();
    s_period();
    s_unmapped();
    close_out();
  end
endmodule : testbench
`default_nettype wire
